// *** rtl/cfg_port_map.vh ***
`ifndef CFG_PORT_MAP_VH
`define CFG_PORT_MAP_VH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define OFS_CTRL          8'h00
`define OFS_LENGTH        8'h04
`define OFS_STATUS        8'h08
`define OFS_USER_IO       8'h0c
`define OFS_PIN_IN        8'h10
// ----------------------------------------
// control fields
// ----------------------------------------
`define CTRL_MODE_LO      0
`define CTRL_MODE_HI      1
`define CTRL_USRCLK_EN    2
`define CTRL_INITDONE_EN  3
`define CTRL_GOE_EN       4
`define CTRL_GCLR_EN      5
`define CTRL_DUAL_USER    6
`define CTRL_RESET        7'h00
`define MODE_PS           2'h0
`define MODE_FPP          2'h1
`define MODE_AS           2'h2
// ----------------------------------------
// status fields
// ----------------------------------------
`define ST_STATE_LO       0
`define ST_STATE_HI       2
`define ST_OVERFLOW       3
`define ST_COUNT_LO       16
`define LENGTH_RESET      16'h0010
`define USER_IO_RESET     16'h0000
// ----------------------------------------
// loader states
// ----------------------------------------
`define S_HOLD            3'h0
`define S_CONFIG          3'h1
`define S_INIT            3'h2
`define S_USER            3'h3
`define S_WAIT_CE         3'h4
// ----------------------------------------
// timing
// ----------------------------------------
`define HCLK_PERIOD_NS    10
`define AS_HALF_NS        40
`define INIT_TICKS        8'h20
`endif

// *** rtl/config_data_port.v ***
// Functional notes
// - passive modes: capture data on config_clock rise
// - active serial: device drives config_clock out
// - after config tri-state clock; AS holds low
// - serial modes: one bit per clock
// - parallel mode: one byte per clock
// - serial modes: upper data pins stay tri-stated; passive serial with dual-user drives them after config
// - after passive config data pins become user
// - disabled option pins: user I/O, pulled up; pull-ups drop in user mode
// - user startup clock times initialization
// - init-done released while restart low/early
// - init-done driven low after first frame
// - init done: release init-done, enter user
// - global output enable low tri-states all I/O
// - global clear low clears all registers
// - config_loaded low until data complete
//
// Decided for this implementation: the address map and the AHB-Lite interface to the registers.
`include "cfg_port_map.vh"
`default_nettype none
module config_data_port
(
  input  wire        hclk,                 // system clock
  input  wire        hresetn,              // async reset, active low
  input  wire        hsel,                 // ahb select
  input  wire [31:0] haddr,                // ahb address
  input  wire [1:0]  htrans,               // ahb transfer type
  input  wire        hwrite,               // ahb write
  input  wire [2:0]  hsize,                // ahb size
  input  wire [31:0] hwdata,               // ahb write data
  input  wire        hready,               // ahb bus ready
  output wire        hreadyout,            // ahb slave ready
  output reg  [31:0] hrdata,               // ahb read data
  output wire        hresp,                // ahb response
  input  wire        config_clock_in,      // clock pin level
  output wire        config_clock_out,     // clock pin drive
  output wire        config_clock_oe,      // clock pin enable
  input  wire [7:0]  data_in,              // data pins, bit 0 serial
  output wire [7:0]  data_out,             // data pins user drive
  output wire [7:0]  data_oe,              // data pins enable
  input  wire        config_restart_n,     // restart, active low
  input  wire        chip_enable_n,        // chip enable, active low
  output wire        config_loaded_oe,     // open drain pull low
  output wire        init_done_oe,         // open drain pull low
  input  wire        user_startup_clock,   // optional startup clock
  input  wire        global_output_enable, // optional io enable
  input  wire        global_register_clear_n, // optional clear
  output wire [3:0]  option_pullup_en,     // weak pull-ups on
  output wire        device_clear_n,       // clear to device regs
  output wire        io_tristate_all,      // force all io off
  output wire [7:0]  cfg_byte,             // loaded config byte
  output wire        cfg_valid,            // byte available
  input  wire        cfg_ready,            // consumer takes byte
  output wire        user_mode             // device in user mode
);
  localparam integer AS_HALF_INT = `AS_HALF_NS / `HCLK_PERIOD_NS;
  localparam [7:0]   AS_HALF_CYC = AS_HALF_INT[7:0];
  function hit;
    input [7:0] a;
    input [7:0] ofs;
    hit = (a == ofs);
  endfunction
  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  reg [13:0] s1_reg;
  reg [13:0] s2_reg;
  reg [1:0]  s3_reg;
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s1_reg <= 14'h0000;
      s2_reg <= 14'h0000;
      s3_reg <= 2'h0;
    end
    else
    begin
      s1_reg <= {config_clock_in, user_startup_clock, config_restart_n,
                 chip_enable_n, global_output_enable,
                 global_register_clear_n, data_in};
      s2_reg <= s1_reg;
      s3_reg <= s2_reg[13:12];
    end
  end
  wire       clk_rise  = s2_reg[13] & ~s3_reg[1];
  wire       usr_rise  = s2_reg[12] & ~s3_reg[0];
  wire       restart_n = s2_reg[11];
  wire       ce_n      = s2_reg[10];
  wire       goe_pin   = s2_reg[9];
  wire       gclr_pin  = s2_reg[8];
  wire [7:0] din       = s2_reg[7:0];
  // ----------------------------------------
  // registers and ahb slave
  // ----------------------------------------
  reg [6:0]  ctrl_reg;
  reg [15:0] length_reg;
  reg [15:0] user_io_reg;
  reg [7:0]  addr_reg;
  reg        wr_reg;
  reg [2:0]  state_reg;
  reg [15:0] count_reg;
  reg        ovf_reg;
  wire [1:0] mode      = ctrl_reg[`CTRL_MODE_HI:`CTRL_MODE_LO];
  wire       goe_en    = ctrl_reg[`CTRL_GOE_EN];
  wire       gclr_en   = ctrl_reg[`CTRL_GCLR_EN];
  wire       gclr      = gclr_en & ~gclr_pin;
  wire       take      = hsel & hready & htrans[1];
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      addr_reg <= 8'h00;
      wr_reg   <= 1'b0;
      hrdata   <= 32'h0000_0000;
    end
    else
    begin
      wr_reg <= take & hwrite;
      if (take)
        addr_reg <= haddr[7:0];
      if (take & ~hwrite)
      begin
        if (hit(haddr[7:0], `OFS_CTRL))
          hrdata <= {25'h000_0000, ctrl_reg};
        else if (hit(haddr[7:0], `OFS_LENGTH))
          hrdata <= {16'h0000, length_reg};
        else if (hit(haddr[7:0], `OFS_STATUS))
          hrdata <= {count_reg, 12'h000, ovf_reg, state_reg};
        else if (hit(haddr[7:0], `OFS_USER_IO))
          hrdata <= {16'h0000, user_io_reg};
        else if (hit(haddr[7:0], `OFS_PIN_IN))
          hrdata <= {20'h0_0000, ce_n, restart_n, goe_pin, gclr_pin, din};
        else
          hrdata <= 32'h0000_0000;
      end
    end
  end

  // clear pin wipes length and user io registers too, option gated
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl_reg    <= `CTRL_RESET;
      length_reg  <= `LENGTH_RESET;
      user_io_reg <= `USER_IO_RESET;
    end
    else if (gclr)
    begin
      length_reg  <= `LENGTH_RESET;
      user_io_reg <= `USER_IO_RESET;
    end
    else if (wr_reg)
    begin
      if (hit(addr_reg, `OFS_CTRL))
        ctrl_reg <= hwdata[6:0];
      if (hit(addr_reg, `OFS_LENGTH))
        length_reg <= hwdata[15:0];
      if (hit(addr_reg, `OFS_USER_IO))
        user_io_reg <= hwdata[15:0];
    end
  end
  // ----------------------------------------
  // two-entry output buffer
  // ----------------------------------------
  reg [7:0] buf_mem [0:1];
  reg       wp_reg;
  reg       rp_reg;
  reg [1:0] fill_reg;
  wire      buf_full  = fill_reg[1];
  wire      push;
  wire [7:0] push_byte;
  wire      pop = cfg_valid & cfg_ready;
  assign cfg_valid = (fill_reg != 2'h0);
  assign cfg_byte  = buf_mem[rp_reg];
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wp_reg     <= 1'b0;
      rp_reg     <= 1'b0;
      fill_reg   <= 2'h0;
      buf_mem[0] <= 8'h00;
      buf_mem[1] <= 8'h00;
    end
    else
    begin
      if (push)
      begin
        buf_mem[wp_reg] <= push_byte;
        wp_reg          <= ~wp_reg;
      end
      if (pop)
        rp_reg <= ~rp_reg;
      fill_reg <= fill_reg + {1'b0, push} - {1'b0, pop};
    end
  end
  // ----------------------------------------
  // loader
  // ----------------------------------------
  reg [7:0]  shift_reg;
  reg [2:0]  bit_reg;
  reg [7:0]  div_reg;
  reg        as_clk_reg;
  reg        frame1_reg;
  reg [7:0]  init_reg;
  reg [2:0]  state_next;
  wire       in_cfg   = (state_reg == `S_CONFIG);
  wire       as_mode  = (mode == `MODE_AS);
  // active serial pauses its own clock when the buffer is full
  wire       as_tick  = in_cfg & as_mode & ~buf_full &
                        (div_reg == AS_HALF_CYC - 8'h01);
  wire       as_fall  = as_tick & as_clk_reg;
  wire       edge_ok  = as_mode ? as_fall : clk_rise;
  wire       cap      = in_cfg & edge_ok;
  wire       serial   = (mode != `MODE_FPP);
  wire [7:0] ser_byte = {din[0], shift_reg[7:1]};
  wire       byte_done = cap & (~serial | (bit_reg == 3'h7));
  wire       last     = byte_done & (count_reg + 16'h0001 >= length_reg);
  wire       init_tick = ctrl_reg[`CTRL_USRCLK_EN] ? usr_rise : 1'b1;
  // a byte meeting a full buffer is dropped and flagged, never overwrites
  assign push      = byte_done & (~buf_full | pop);
  assign push_byte = serial ? ser_byte : din;
  always @*
  begin
    state_next = state_reg;
    case (state_reg)
      `S_HOLD:
        state_next = `S_WAIT_CE;
      `S_WAIT_CE:
        if (!ce_n)
          state_next = `S_CONFIG;
      `S_CONFIG:
        if (last)
          state_next = `S_INIT;
      `S_INIT:
        if (init_reg == `INIT_TICKS && init_tick)
          state_next = `S_USER;
      `S_USER:
        state_next = `S_USER;
      default:
        state_next = `S_HOLD;
    endcase
    if (!restart_n)
      state_next = `S_HOLD;
  end

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_reg  <= `S_HOLD;
      shift_reg  <= 8'h00;
      bit_reg    <= 3'h0;
      count_reg  <= 16'h0000;
      ovf_reg    <= 1'b0;
      div_reg    <= 8'h00;
      as_clk_reg <= 1'b0;
      frame1_reg <= 1'b0;
      init_reg   <= 8'h00;
    end
    else
    begin
      state_reg <= state_next;
      if (state_next == `S_HOLD)
      begin
        bit_reg    <= 3'h0;
        count_reg  <= 16'h0000;
        ovf_reg    <= 1'b0;
        div_reg    <= 8'h00;
        as_clk_reg <= 1'b0;
        frame1_reg <= 1'b0;
        init_reg   <= 8'h00;
      end
      else
      begin
        if (cap)
        begin
          shift_reg <= ser_byte;
          bit_reg   <= bit_reg + 3'h1;
        end
        if (byte_done)
        begin
          count_reg  <= count_reg + 16'h0001;
          frame1_reg <= 1'b1;
          if (buf_full & ~pop)
            ovf_reg <= 1'b1;
        end
        if (in_cfg & as_mode & ~buf_full)
        begin
          div_reg <= as_tick ? 8'h00 : div_reg + 8'h01;
          if (as_tick)
            as_clk_reg <= ~as_clk_reg;
        end
        if (~in_cfg)
          as_clk_reg <= 1'b0;
        if (state_reg == `S_INIT && init_tick &&
            init_reg != `INIT_TICKS)
          init_reg <= init_reg + 8'h01;
      end
    end
  end

  // ----------------------------------------
  // pin drives
  // ----------------------------------------
  wire after_cfg = (state_reg == `S_INIT) | (state_reg == `S_USER);
  wire io_off    = goe_en & ~goe_pin;
  wire data_user = ~as_mode & after_cfg & ctrl_reg[`CTRL_DUAL_USER];

  assign user_mode        = (state_reg == `S_USER);
  // memory schemes park the clock low, host schemes let it float
  assign config_clock_out = as_clk_reg;
  assign config_clock_oe  = as_mode & (in_cfg | after_cfg);
  assign config_loaded_oe = ~after_cfg;
  assign init_done_oe     = ctrl_reg[`CTRL_INITDONE_EN] &
                            frame1_reg &
                            (state_reg != `S_USER);
  // serial schemes keep pins 7..1 released while loading
  assign data_out = user_io_reg[7:0];
  assign data_oe  = (data_user & ~io_off) ?
                    user_io_reg[15:8] : 8'h00;
  assign io_tristate_all  = io_off;
  assign device_clear_n   = ~gclr;
  assign option_pullup_en = {~ctrl_reg[`CTRL_GCLR_EN],
                             ~ctrl_reg[`CTRL_GOE_EN],
                             ~ctrl_reg[`CTRL_INITDONE_EN],
                             ~ctrl_reg[`CTRL_USRCLK_EN]} &
                            {4{~user_mode}};
endmodule
`default_nettype wire

// *** tb/config_data_port_bench.sv ***
`include "cfg_port_map.vh"
`default_nettype none
module config_data_port_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, user_mode;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic        config_restart_n, global_output_enable, cfg_ready;
  logic        global_register_clear_n, cfg_valid, device_clear_n;
  logic        config_clock_out, config_clock_oe, config_loaded_oe;
  logic        init_done_oe, io_tristate_all, host_clk, clk_pin;
  logic [7:0]  data_out, data_oe, host_dat, pins, cfg_byte;
  logic [3:0]  option_pullup_en;
  logic        chip_enable_n, usr_clk;
  int          n_fail = 0;
  int          check_count = 0;
  assign clk_pin = config_clock_oe ? config_clock_out : host_clk;
  assign pins    = (data_oe & data_out) | (~data_oe & host_dat);
  config_data_port dut
  (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
    .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp,
    .config_clock_in(clk_pin), .config_clock_out, .config_clock_oe,
    .data_in(pins), .data_out, .data_oe, .config_restart_n,
    .chip_enable_n, .config_loaded_oe, .init_done_oe,
    .user_startup_clock(usr_clk), .global_output_enable,
    .global_register_clear_n, .option_pullup_en, .device_clear_n,
    .io_tristate_all, .cfg_byte, .cfg_valid, .cfg_ready, .user_mode
  );
  config_host_model host
  (
    .as_clk(clk_pin), .as_on(config_clock_oe), .host_clk, .host_dat
  );
  initial
  begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic cmp(input logic [31:0] got, exp, input string what);
    check_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {24'h00_0000, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic await(ref logic s, input int n);
    repeat (n)
      if (s !== 1'b1)
        @(posedge hclk);
  endtask
  task automatic restart(input logic [7:0] ctrl, len);
    ahb(1'b1, `OFS_CTRL, {24'h00_0000, ctrl});
    ahb(1'b1, `OFS_LENGTH, {24'h00_0000, len});
    config_restart_n <= 1'b0;
    repeat (6) @(posedge hclk);
    cmp(init_done_oe, 1'b0, "done released");
    cmp(config_loaded_oe, 1'b1, "loaded held");
    config_restart_n <= 1'b1;
    repeat (6) @(posedge hclk);
  endtask
  task automatic pop(input logic [7:0] exp);
    @(posedge hclk);
    await(cfg_valid, 200);
    cmp(cfg_valid, 1'b1, "byte pending");
    cmp(cfg_byte, exp, "byte");
    cfg_ready <= 1'b1;
    @(posedge hclk);
    cfg_ready <= 1'b0;
    @(posedge hclk);
  endtask
  task automatic usr_ticks(input int n);
    repeat (n)
    begin
      usr_clk <= 1'b1;
      repeat (4) @(posedge hclk);
      usr_clk <= 1'b0;
      repeat (4) @(posedge hclk);
    end
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    ahb(1'b0, `OFS_CTRL, 32'h0000_0000);
    cmp(rd, `CTRL_RESET, "ctrl reset");
    ahb(1'b0, `OFS_LENGTH, 32'h0000_0000);
    cmp(rd, 32'h0000_0010, "length reset");
    ahb(1'b0, 8'h40, 32'h0000_0000);
    cmp(rd, 32'h0000_0000, "unmapped");
    cmp({hreadyout, hresp}, 2'b10, "okay response");
    cmp(option_pullup_en, 4'hf, "pull-ups");
    $display("t_reset done");
  endtask
  task automatic t_serial;
    restart(8'h48, 8'h02);
    host.send(8'ha5, 1'b0);
    pop(8'ha5);
    cmp(init_done_oe, 1'b1, "done low");
    cmp(data_oe, 8'h00, "pins off");
    host.send(8'h3c, 1'b0);
    pop(8'h3c);
    await(user_mode, 300);
    cmp(init_done_oe, 1'b0, "done up");
    cmp(config_loaded_oe, 1'b0, "loaded up");
    cmp(config_clock_oe, 1'b0, "clock off");
    host.send(8'h77, 1'b0);
    repeat (8) @(posedge hclk);
    cmp(cfg_valid, 1'b0, "late clock");
    ahb(1'b1, `OFS_USER_IO, 32'h0000_ff5a);
    @(posedge hclk);
    cmp({data_oe, data_out}, 16'hff5a, "user pins");
    cmp(option_pullup_en, 4'h0, "pulls off");
    $display("t_serial done");
  endtask
  task automatic t_parallel;
    restart(8'h05, 8'h03);
    host.send(8'h11, 1'b1);
    host.send(8'h22, 1'b1);
    host.send(8'h33, 1'b1);
    repeat (8) @(posedge hclk);
    ahb(1'b0, `OFS_STATUS, 32'h0000_0000);
    cmp(rd[3], 1'b1, "overflow");
    cmp(rd[2:0], `S_INIT, "init waits for user clock");
    pop(8'h11);
    pop(8'h22);
    cmp(cfg_valid, 1'b0, "drained");
    usr_ticks(32);
    cmp(user_mode, 1'b0, "init still counting");
    usr_ticks(1);
    cmp(user_mode, 1'b1, "init timed by user clock");
    $display("t_parallel done");
  endtask
  task automatic t_global;
    ahb(1'b1, `OFS_CTRL, 32'h0000_0030);
    global_output_enable <= 1'b0;
    repeat (4) @(posedge hclk);
    cmp(io_tristate_all, 1'b1, "io off");
    global_output_enable    <= 1'b1;
    global_register_clear_n <= 1'b0;
    repeat (4) @(posedge hclk);
    cmp(device_clear_n, 1'b0, "clear");
    global_register_clear_n <= 1'b1;
    repeat (4) @(posedge hclk);
    ahb(1'b0, `OFS_LENGTH, 32'h0000_0000);
    cmp(rd, 32'h0000_0010, "length cleared");
    $display("t_global done");
  endtask
  task automatic t_active;
    chip_enable_n <= 1'b1;
    restart(8'h02, 8'h01);
    cmp(config_clock_oe, 1'b0, "waits for enable");
    chip_enable_n <= 1'b0;
    await(config_clock_oe, 50);
    cmp(config_clock_oe, 1'b1, "clock driven");
    pop(8'hc3);
    await(user_mode, 400);
    cmp(config_clock_out, 1'b0, "clock low");
    $display("t_active done");
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    hresetn                 = 1'b0;
    hsel                    = 1'b0;
    htrans                  = 2'b00;
    haddr                   = 32'h0000_0000;
    hwrite                  = 1'b0;
    hwdata                  = 32'h0000_0000;
    config_restart_n        = 1'b1;
    global_output_enable    = 1'b1;
    global_register_clear_n = 1'b1;
    cfg_ready               = 1'b0;
    chip_enable_n           = 1'b0;
    usr_clk                 = 1'b0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset;
    t_serial;
    t_parallel;
    t_global;
    t_active;
    wrap_up;
  end
  initial
  begin
    #500000;
    n_fail++;
    $display("MISMATCH %0t watchdog expired", $time);
    wrap_up;
  end
endmodule
`default_nettype wire

// *** tb/config_data_port_properties.sv ***
`default_nettype none
module config_data_port_properties
(
  input wire logic       hclk,                    // clock
  input wire logic       hresetn,                 // reset
  input wire logic       user_mode,               // user
  input wire logic       config_clock_out,        // clk drive
  input wire logic       config_clock_oe,         // clk enable
  input wire logic       config_loaded_oe,        // loaded pull
  input wire logic       init_done_oe,            // done pull
  input wire logic       config_restart_n,        // restart
  input wire logic       global_output_enable,    // oe pin
  input wire logic       io_tristate_all,         // io off
  input wire logic       global_register_clear_n, // clr pin
  input wire logic       device_clear_n,          // clr out
  input wire logic [7:0] data_oe,                 // data enables
  input wire logic [3:0] option_pullup_en,        // pull-ups
  input wire logic       cfg_valid,               // byte ready
  input wire logic       cfg_ready,               // byte taken
  input wire logic [7:0] cfg_byte                 // byte
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  chk_clock_parked: assert property (
    user_mode && $past(user_mode) |-> !(config_clock_oe && config_clock_out))
    else $error("clock pin high in user mode");
  chk_done_released: assert property (
    !config_restart_n [*4] |-> !init_done_oe)
    else $error("done pin pulled during restart");
  chk_loaded_held: assert property (
    !config_restart_n [*4] |-> config_loaded_oe)
    else $error("loaded pin released during restart");
  chk_done_user: assert property (
    user_mode && $past(user_mode) |-> !init_done_oe)
    else $error("done pin pulled in user mode");
  chk_oe_follows: assert property (
    global_output_enable [*4] |-> !io_tristate_all)
    else $error("io forced off with enable high");
  chk_clear_follows: assert property (
    global_register_clear_n [*4] |-> device_clear_n)
    else $error("clear active with pin high");
  chk_pins_idle: assert property (
    !user_mode && !$past(user_mode) |-> data_oe == 8'h00)
    else $error("data pin driven before user mode");
  chk_pulls_off: assert property (
    user_mode && $past(user_mode) |-> option_pullup_en == 4'h0)
    else $error("pull-up kept in user mode");
  chk_byte_held: assert property (
    cfg_valid && !cfg_ready && config_restart_n |=>
    cfg_valid && $stable(cfg_byte))
    else $error("stalled byte lost");
  cover property ($rose(user_mode));
  cover property (io_tristate_all);
  cover property (cfg_valid && !cfg_ready);
endmodule
bind config_data_port config_data_port_properties chk
(
  .hclk, .hresetn, .user_mode, .config_clock_out, .config_clock_oe,
  .config_loaded_oe, .init_done_oe, .config_restart_n,
  .global_output_enable, .io_tristate_all, .global_register_clear_n,
  .device_clear_n, .data_oe, .option_pullup_en, .cfg_valid, .cfg_ready,
  .cfg_byte
);
`default_nettype wire

// *** tb/config_host_model.sv ***
`default_nettype none
module config_host_model
(
  input  wire logic       as_clk,   // device clock
  input  wire logic       as_on,    // memory selected
  output var  logic       host_clk, // host clock
  output var  logic [7:0] host_dat  // data drive
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem_byte = 8'hc3;
  logic [2:0] mem_bit  = 3'h0;
  initial
  begin
    host_clk = 1'b0;
    host_dat = 8'h00;
  end
  // clock parks low between frames; data inverts so stale bits show
  task automatic send(input logic [7:0] b, input logic par);
    for (int i = 0; i < (par ? 1 : 8); i++)
    begin
      host_dat = par ? b : {host_dat[7:1], b[i]};
      #63 host_clk = 1'b1;
      #62 host_clk = 1'b0;
    end
    host_dat = ~host_dat;
  endtask
  // memory puts a bit out on each rise, so it is steady at the fall
  always @(posedge as_clk)
    if (as_on)
    begin
      host_dat[0] <= mem_byte[mem_bit];
      mem_bit     <= mem_bit + 3'h1;
    end
endmodule
`default_nettype wire
